// ===== pkg/ssoi_pkg.sv
// Purpose: Shared constants and types for the safety output image framer
// Assumes: 125 MHz system clock, byte-wide image stream
// Notes: Image layouts for the long (16 byte) and short (10 byte) formats
`default_nettype none
package ssoi_pkg;
  // ==========================================================
  // Timing
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned BASE_PERIOD_US = 5000;
  localparam int unsigned BASE_CYCLES = BASE_PERIOD_US * CLK_MHZ;
  // ==========================================================
  // Image lengths and byte positions
  localparam int unsigned LONG_LEN = 16;
  localparam int unsigned SHORT_LEN = 10;
  localparam logic [3:0] BYTE_STATUS = 4'h0;
  localparam logic [3:0] BYTE_SAFE = 4'h1;
  localparam logic [3:0] BYTE_NONSAFE = 4'h4;
  localparam logic [3:0] BYTE_RESET = 4'h7;
  localparam logic [3:0] BYTE_CASE_ONE = 4'ha;
  localparam logic [3:0] BYTE_CASE_FOUR = 4'hd;
  localparam logic [3:0] BYTE_LONG_FAULT = 4'hf;
  localparam logic [3:0] BYTE_SHORT_FAULT = 4'h9;
  // ==========================================================
  // Field positions
  localparam int unsigned BIT_RUN = 0;
  localparam int unsigned BIT_STANDBY = 1;
  localparam int unsigned BIT_DIRT_WARN = 2;
  localparam int unsigned BIT_DIRT_ERR = 3;
  localparam int unsigned BIT_CONTOUR = 4;
  localparam int unsigned BIT_TAMPER = 5;
  localparam int unsigned BIT_LONG_UNIT = 1;
  localparam int unsigned BIT_LONG_CFG = 0;
  localparam int unsigned BIT_SHORT_UNIT = 7;
  localparam int unsigned BIT_SHORT_CFG = 6;
  localparam int unsigned BASIC_PATHS = 4;
  localparam logic [7:0] RESERVED_VAL = 8'h00;
  // ==========================================================
  // Framer states, Gray along idle, send, gap
  typedef enum logic [1:0] {
    SSOI_IDLE = 2'b00,
    SSOI_SEND = 2'b01,
    SSOI_WAIT = 2'b11
  } ssoi_state_t;
endpackage
`default_nettype wire

// ===== pkg/ssoi_stream_if.sv
// Purpose: Byte stream carrier between framer and FIFO
// Assumes: Single clock domain
// Notes: Valid/ready handshake, last marks final image byte
`default_nettype none
interface ssoi_stream_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  logic last;
  modport src (output valid, output data, output last, input ready);
  modport snk (input valid, input data, input last, output ready);
endinterface
`default_nettype wire

// ===== core/ssoi_fifo.sv
// Purpose: Synchronous FIFO buffering image bytes toward the link
// Assumes: One clock, asynchronous active-high reset
// Notes: Width includes the last flag; depth must be a power of two
`default_nettype none
module ssoi_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 32
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Fill side
  input wire logic i_valid,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_ready,
  // Drain side
  output logic o_valid,
  output logic [WIDTH-1:0] o_data,
  input wire logic i_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  // ==========================================================
  // Parameter check
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
      $error("ssoi_fifo: DEPTH must be a power of two >= 2");
    end
  end
  // ==========================================================
  // Storage and pointers
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_q, wp_d, rp_q, rp_d;
  logic push, pop, full, empty;
  // Extra pointer bit tells full from empty
  always_comb begin
    full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
    empty = (wp_q == rp_q);
    push = i_valid && !full;
    pop = !empty && i_ready;
    wp_d = push ? wp_q + 1'b1 : wp_q;
    rp_d = pop ? rp_q + 1'b1 : rp_q;
  end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
  end
  // Memory holds no reset; only written entries are ever read
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wp_q[AW-1:0]] <= i_data;
    end
  end
  assign o_ready = !full;
  assign o_valid = !empty;
  assign o_data = mem[rp_q[AW-1:0]];
  // Full FIFO never accepts
  a_fifo_no_overrun: assert property (@(posedge i_clk) disable iff (i_rst)
    full |=> (wp_q == $past(wp_q)))
    else $error("fifo written while full");
endmodule
`default_nettype wire

// ===== core/ssoi_pin_sync.sv
// Purpose: Three-stage input qualifier for pin-level status inputs
// Assumes: Inputs arrive asynchronous to i_clk
// Notes: A change counts once stages two and three agree
`default_nettype none
module ssoi_pin_sync #(
  parameter int unsigned WIDTH = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Levels
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] s1_q, s2_q, s3_q, out_q, out_d;
  // ==========================================================
  // Per-bit qualify: first stage only feeds second
  genvar g;
  for (g = 0; g < WIDTH; g++) begin : g_bit
    always_comb begin
      out_d[g] = (s2_q[g] == s3_q[g]) ? s2_q[g] : out_q[g];
    end
  end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end else begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end
  assign o_sync = out_q;
endmodule
`default_nettype wire

// ===== core/ssoi_framer.sv
// Purpose: Builds the cyclic safety output image and streams it byte 0 first
// Assumes: Status inputs come from pins; case numbers are stable on i_clk
// Notes: Long or short image chosen by i_short_mode, sampled at frame start
`default_nettype none
module ssoi_framer
  import ssoi_pkg::*;
#(
  parameter int unsigned BASE_CNT = ssoi_pkg::BASE_CYCLES,
  parameter int unsigned FIFO_DEPTH = 32
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Configuration
  input wire logic i_short_mode,
  input wire logic i_high_variant,
  input wire logic [7:0] i_requested_packet_interval,
  // Status pins
  input wire logic i_run_active,
  input wire logic i_standby_active,
  input wire logic i_window_dirt_warning,
  input wire logic i_window_dirt_error,
  input wire logic i_contour_reference_status,
  input wire logic i_tamper_status,
  input wire logic i_unit_fault,
  input wire logic i_config_fault,
  input wire logic [7:0] i_safe_path_state,
  input wire logic [7:0] i_nonsafe_path_state,
  input wire logic [7:0] i_path_reset_needed,
  // Monitoring case numbers, same clock
  input wire logic [7:0] i_case_number_tbl_one,
  input wire logic [7:0] i_case_number_tbl_two,
  input wire logic [7:0] i_case_number_tbl_three,
  input wire logic [7:0] i_case_number_tbl_four,
  // Image byte stream
  output logic o_valid,
  output logic [7:0] o_data,
  output logic o_last,
  input wire logic i_ready,
  // Status
  output logic o_busy,
  output logic o_overrun
);
  import ssoi_pkg::*;
  localparam int unsigned CW = $clog2(BASE_CNT + 1);
  // ==========================================================
  // Parameter check
  initial begin
    if (BASE_CNT < 2 || FIFO_DEPTH < LONG_LEN) begin
      $error("ssoi_framer: BASE_CNT >= 2 and FIFO_DEPTH >= 16 required");
    end
  end
  // ==========================================================
  // Pin qualification
  localparam int unsigned NPIN = 32;
  logic [NPIN-1:0] pin_raw, pin_q;
  assign pin_raw = {i_path_reset_needed, i_nonsafe_path_state, i_safe_path_state,
                    i_config_fault, i_unit_fault, i_tamper_status,
                    i_contour_reference_status, i_window_dirt_error,
                    i_window_dirt_warning, i_standby_active, i_run_active};
  ssoi_pin_sync #(.WIDTH(NPIN)) u_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async(pin_raw),
    .o_sync(pin_q)
  );
  logic [7:0] safe_s, nonsafe_s, reset_s;
  assign safe_s = pin_q[15:8];
  assign nonsafe_s = pin_q[23:16];
  assign reset_s = pin_q[31:24];
  // ==========================================================
  // Base tick and interval counter
  logic [CW-1:0] tick_cnt_q, tick_cnt_d;
  logic [7:0] mult_cnt_q, mult_cnt_d;
  logic frame_due;
  logic [7:0] mult_eff;
  always_comb begin
    mult_eff = (i_requested_packet_interval == 8'h00) ? 8'h01 : i_requested_packet_interval;
    frame_due = 1'b0;
    tick_cnt_d = tick_cnt_q + 1'b1;
    mult_cnt_d = mult_cnt_q;
    if (tick_cnt_q == CW'(BASE_CNT - 1)) begin
      tick_cnt_d = '0;
      if (mult_cnt_q + 8'h01 >= mult_eff) begin
        mult_cnt_d = 8'h00;
        frame_due = 1'b1;
      end else begin
        mult_cnt_d = mult_cnt_q + 8'h01;
      end
    end
  end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tick_cnt_q <= '0;
      mult_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      mult_cnt_q <= mult_cnt_d;
    end
  end
  // ==========================================================
  // Snapshot: whole image frozen at frame start for consistency
  logic [7:0] img_q [LONG_LEN];
  logic [7:0] img_d [LONG_LEN];
  logic short_q, short_d;
  logic [7:0] path_mask;
  logic [7:0] status_byte;
  logic take;
  always_comb begin
    // Basic variant reports upper paths as unavailable (zero)
    path_mask = i_high_variant ? 8'hff : 8'((1 << BASIC_PATHS) - 1);
    status_byte = RESERVED_VAL;
    status_byte[BIT_RUN] = pin_q[0];
    status_byte[BIT_STANDBY] = pin_q[1];
    status_byte[BIT_DIRT_WARN] = pin_q[2];
    status_byte[BIT_DIRT_ERR] = pin_q[3];
    status_byte[BIT_CONTOUR] = pin_q[4];
    status_byte[BIT_TAMPER] = pin_q[5];
    short_d = short_q;
    for (int i = 0; i < LONG_LEN; i++) begin
      img_d[i] = img_q[i];
    end
    if (take) begin
      short_d = i_short_mode;
      for (int i = 0; i < LONG_LEN; i++) begin
        img_d[i] = RESERVED_VAL;
      end
      img_d[BYTE_STATUS] = status_byte;
      img_d[BYTE_SAFE] = safe_s & path_mask;
      img_d[BYTE_NONSAFE] = nonsafe_s & path_mask;
      img_d[BYTE_RESET] = reset_s & path_mask;
      if (i_short_mode) begin
        // Qualified pins: bit 6 unit fault, bit 7 config fault
        img_d[BYTE_SHORT_FAULT][BIT_SHORT_UNIT] = pin_q[6];
        img_d[BYTE_SHORT_FAULT][BIT_SHORT_CFG] = pin_q[7];
      end else begin
        img_d[BYTE_CASE_ONE] = i_case_number_tbl_one;
        img_d[BYTE_CASE_ONE + 4'h1] = i_case_number_tbl_two;
        img_d[BYTE_CASE_ONE + 4'h2] = i_case_number_tbl_three;
        img_d[BYTE_CASE_FOUR] = i_case_number_tbl_four;
        img_d[BYTE_LONG_FAULT][BIT_LONG_UNIT] = pin_q[6];
        img_d[BYTE_LONG_FAULT][BIT_LONG_CFG] = pin_q[7];
      end
    end
  end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      short_q <= 1'b0;
      for (int i = 0; i < LONG_LEN; i++) begin
        img_q[i] <= 8'h00;
      end
    end else begin
      short_q <= short_d;
      for (int i = 0; i < LONG_LEN; i++) begin
        img_q[i] <= img_d[i];
      end
    end
  end
  // ==========================================================
  // Frame state machine: emits bytes 0..len-1 into the FIFO
  ssoi_state_t st_q, st_d;
  logic [3:0] idx_q, idx_d;
  logic overrun_q, overrun_d;
  logic [3:0] last_idx;
  ssoi_stream_if fill ();
  assign last_idx = short_q ? 4'(SHORT_LEN - 1) : 4'(LONG_LEN - 1);
  always_comb begin
    st_d = st_q;
    idx_d = idx_q;
    take = 1'b0;
    overrun_d = overrun_q;
    fill.valid = 1'b0;
    fill.data = img_q[idx_q];
    fill.last = (idx_q == last_idx);
    case (st_q)
      SSOI_IDLE: begin
        if (frame_due) begin
          take = 1'b1;
          idx_d = 4'h0;
          st_d = SSOI_SEND;
        end
      end
      SSOI_SEND: begin
        fill.valid = 1'b1;
        if (fill.ready) begin
          idx_d = idx_q + 4'h1;
          if (idx_q == last_idx) begin
            idx_d = 4'h0;
            st_d = SSOI_WAIT;
          end
        end
        // A due frame while still sending is dropped, not queued
        if (frame_due) begin
          overrun_d = 1'b1;
        end
      end
      SSOI_WAIT: begin
        st_d = SSOI_IDLE;
        if (frame_due) begin
          overrun_d = 1'b1;
        end
      end
      default: begin
        st_d = SSOI_IDLE;
        idx_d = 4'h0;
      end
    endcase
  end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q <= SSOI_IDLE;
      idx_q <= 4'h0;
      overrun_q <= 1'b0;
    end else begin
      st_q <= st_d;
      idx_q <= idx_d;
      overrun_q <= overrun_d;
    end
  end
  assign o_busy = (st_q != SSOI_IDLE);
  assign o_overrun = overrun_q;
  // ==========================================================
  // Output buffer; downstream stalls back-pressure the framer
  logic [8:0] fifo_out;
  ssoi_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_valid(fill.valid),
    .i_data({fill.last, fill.data}),
    .o_ready(fill.ready),
    .o_valid(o_valid),
    .o_data(fifo_out),
    .i_ready(i_ready)
  );
  assign o_data = fifo_out[7:0];
  assign o_last = fifo_out[8];
  // ==========================================================
  // Checks
  sequence s_start;
    (st_q == SSOI_IDLE) && frame_due;
  endsequence
  sequence s_first_byte;
    (st_q == SSOI_SEND) && (idx_q == 4'h0);
  endsequence
  a_frame_starts: assert property (@(posedge i_clk) disable iff (i_rst)
    s_start |=> s_first_byte)
    else $error("frame did not start at byte 0");
  a_status_resv_zero: assert property (@(posedge i_clk) disable iff (i_rst)
    img_q[BYTE_STATUS][7:6] == 2'b00)
    else $error("byte 0 reserved bits set");
  a_basic_masks_paths: assert property (@(posedge i_clk) disable iff (i_rst)
    take && !i_high_variant |=> (img_q[BYTE_SAFE][7:4] == 4'h0)
    && (img_q[BYTE_NONSAFE][7:4] == 4'h0) && (img_q[BYTE_RESET][7:4] == 4'h0))
    else $error("upper paths leaked in basic variant");
  a_long_last_15: assert property (@(posedge i_clk) disable iff (i_rst)
    fill.valid && fill.last && !short_q |-> idx_q == 4'hf)
    else $error("long frame length wrong");
  a_short_last_9: assert property (@(posedge i_clk) disable iff (i_rst)
    fill.valid && fill.last && short_q |-> idx_q == 4'h9)
    else $error("short frame length wrong");
  a_short_fault_map: assert property (@(posedge i_clk) disable iff (i_rst)
    take && i_short_mode |=> img_q[BYTE_SHORT_FAULT] == {$past(pin_q[6]),
    $past(pin_q[7]), 6'h00})
    else $error("short fault byte wrong");
  a_long_case_map: assert property (@(posedge i_clk) disable iff (i_rst)
    take && !i_short_mode |=> img_q[BYTE_CASE_FOUR] == $past(i_case_number_tbl_four)
    && img_q[BYTE_LONG_FAULT] == {6'h00, $past(pin_q[6]), $past(pin_q[7])})
    else $error("long case or fault byte wrong");
  a_status_map: assert property (@(posedge i_clk) disable iff (i_rst)
    take |=> img_q[BYTE_STATUS][5:0] == $past(pin_q[5:0]))
    else $error("status byte wrong");
  a_tick_period: assert property (@(posedge i_clk) disable iff (i_rst)
    tick_cnt_q <= CW'(BASE_CNT - 1))
    else $error("base tick counter overran");
  // Dropped-frame flag is sticky; only reset may lower it
  a_overrun_sticky: assert property (@(posedge i_clk) disable iff (i_rst)
    o_overrun |=> o_overrun)
    else $error("overrun flag fell without reset");
  // Reserved whole bytes of a fresh snapshot are zero
  a_resv_bytes_zero: assert property (@(posedge i_clk) disable iff (i_rst)
    take |=> (img_q[2] == 8'h00) && (img_q[3] == 8'h00) && (img_q[5] == 8'h00)
    && (img_q[6] == 8'h00) && (img_q[8] == 8'h00) && (img_q[14] == 8'h00))
    else $error("reserved image byte set");
endmodule
`default_nettype wire

// ===== verif/ssoi_ctrl_model.sv
// Purpose: Consumer model that takes image bytes from the framer
// Assumes: Ready changes on the falling clock edge only
// Notes: Mode 0 always ready, 1 random stalls, 2 held off
`default_nettype none
module ssoi_ctrl_model (
  // Clock
  input wire logic i_clk,
  // Pace chosen by the bench
  input wire logic [1:0] i_mode,
  // Stream acceptance
  output logic o_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] lf_q = 8'h5a;
  logic rdy_q = 1'b1;
  // ==========================================================
  // Ready pattern
  // Ready every cycle in mode 0, on LFSR bit 0 in mode 1, never in modes 2 and 3
  // Reserved bits carry no meaning for this consumer
  assign o_ready = rdy_q;
  always @(negedge i_clk) begin
    lf_q <= {lf_q[6:0], lf_q[7] ^ lf_q[5] ^ lf_q[4] ^ lf_q[3]};
    rdy_q <= (i_mode == 2'h0) || (i_mode == 2'h1 && lf_q[0]);
  end
endmodule
`default_nettype wire

// ===== verif/scanner_safety_output_image_bench.sv
// Purpose: Self-checking bench for the safety output image framer
// Assumes: Short base count so the run stays brief
// Notes: Each image is checked only after two images past an input change
`default_nettype none
module scanner_safety_output_image_bench import ssoi_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BCNT = 50;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic short_m = 1'b0;
  logic high_v = 1'b1;
  logic [7:0] requested_packet_interval = 8'h01;
  logic [7:0] st = 8'h00;
  logic [7:0] safe = 8'h00, nsafe = 8'h00, rneed = 8'h00;
  logic [7:0] c1 = 8'h00, c2 = 8'h00, c3 = 8'h00, c4 = 8'h00;
  logic [1:0] mode = 2'h0;
  logic rdy, vld, last, busy, ovr;
  logic [7:0] dat;
  logic [7:0] exp_img [16];
  int exp_len;
  logic [15:0] lf = 16'd54;
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  // ==========================================================
  // Clock, timeout and instances
  initial forever #4 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      end_of_test();
    end
  end
  ssoi_framer #(.BASE_CNT(BCNT), .FIFO_DEPTH(32)) i_ssoi_framer (
    .i_clk(clk), .i_rst(rst), .i_short_mode(short_m), .i_high_variant(high_v),
    .i_requested_packet_interval(requested_packet_interval), .i_run_active(st[0]), .i_standby_active(st[1]),
    .i_window_dirt_warning(st[2]), .i_window_dirt_error(st[3]),
    .i_contour_reference_status(st[4]), .i_tamper_status(st[5]), .i_unit_fault(st[6]),
    .i_config_fault(st[7]), .i_safe_path_state(safe), .i_nonsafe_path_state(nsafe),
    .i_path_reset_needed(rneed), .i_case_number_tbl_one(c1), .i_case_number_tbl_two(c2),
    .i_case_number_tbl_three(c3), .i_case_number_tbl_four(c4), .o_valid(vld),
    .o_data(dat), .o_last(last), .i_ready(rdy), .o_busy(busy), .o_overrun(ovr));
  ssoi_ctrl_model i_ssoi_ctrl_model (.i_clk(clk), .i_mode(mode), .o_ready(rdy));
  // ==========================================================
  // Helpers
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  function automatic logic [7:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf[7:0];
  endfunction
  // Expected image from the current pin levels; basic variant hides paths 5..8
  function automatic void fill_exp();
    logic [7:0] m;
    m = high_v ? 8'hff : 8'h0f;
    exp_len = short_m ? SHORT_LEN : LONG_LEN;
    foreach (exp_img[i]) exp_img[i] = 8'h00;
    exp_img[0] = {2'h0, st[5:0]};
    exp_img[1] = safe & m;
    exp_img[4] = nsafe & m;
    exp_img[7] = rneed & m;
    if (short_m) exp_img[9] = {st[6], st[7], 6'h00};
    else begin
      exp_img[10] = c1;
      exp_img[11] = c2;
      exp_img[12] = c3;
      exp_img[13] = c4;
      exp_img[15] = {6'h00, st[6], st[7]};
    end
  endfunction
  // One accepted byte; the global timeout bounds the wait
  task automatic take(output logic [7:0] d, output logic l);
    @(posedge clk);
    while (!(vld === 1'b1 && rdy === 1'b1)) @(posedge clk);
    d = dat;
    l = last;
  endtask
  task automatic skip_frame();
    logic [7:0] d;
    logic l;
    l = 1'b0;
    while (l !== 1'b1) take(d, l);
  endtask
  task automatic collect();
    logic [7:0] d;
    logic l;
    for (int i = 0; i < exp_len; i++) begin
      take(d, l);
      chk("byte", d, exp_img[i]);
      chk("last flag", l, i == exp_len - 1);
    end
  endtask
  // Two images pass first so the snapshot surely holds the new levels
  task automatic run_frame(input logic [7:0] s, sf, ns, rn, cf);
    @(negedge clk);
    st = s;
    safe = sf;
    nsafe = ns;
    rneed = rn;
    short_m = cf[0];
    high_v = cf[1];
    c1 = rnd();
    c2 = rnd();
    c3 = rnd();
    c4 = rnd();
    fill_exp();
    skip_frame();
    skip_frame();
    collect();
  endtask
  task automatic gap_check(input logic [7:0] n);
    int t0;
    @(negedge clk);
    requested_packet_interval = n;
    mode = 2'h0;
    repeat (3) skip_frame();
    t0 = cyc;
    skip_frame();
    chk("frame spacing", cyc - t0, BCNT * ((n == 8'h00) ? 1 : n));
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    // Walking bits over every flag; step v takes its layout from bit 0 and its variant from bit 1
    for (int v = 0; v < 8; v++) run_frame(8'h01 << v, 8'h01 << v, 8'h80 >> v, 8'h01 << v, v);
    for (int v = 0; v < 4; v++) run_frame(8'hff, 8'hff, 8'hff, 8'hff, v);
    // Random images under random consumer stalls
    @(negedge clk);
    mode = 2'h1;
    repeat (12) run_frame(rnd(), rnd(), rnd(), rnd(), rnd());
    // Refresh spacing; zero interval behaves as one
    gap_check(8'h03);
    gap_check(8'h02);
    gap_check(8'h00);
    gap_check(8'h01);
    run_frame(rnd(), rnd(), rnd(), rnd(), 8'h02);
    chk("overrun idle", ovr, 1'b0);
    // Hold the consumer off until the buffer refuses and a frame is dropped
    @(negedge clk);
    mode = 2'h2;
    repeat (BCNT * 6) @(negedge clk);
    chk("busy stuck", busy, 1'b1);
    chk("overrun", ovr, 1'b1);
    @(negedge clk);
    mode = 2'h1;
    collect();
    collect();
    // Second reset in mid-run clears the sticky flag
    @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    chk("valid in reset", vld, 1'b0);
    chk("busy in reset", busy, 1'b0);
    chk("overrun in reset", ovr, 1'b0);
    repeat (16) @(negedge clk);
    rst = 1'b0;
    run_frame(rnd(), rnd(), rnd(), rnd(), 8'h03);
    end_of_test();
  end
endmodule
`default_nettype wire
